// ===== pced_pkg.sv
// Purpose: constants and types shared by the pin change edge detector
// Assumes: apb register map with one 32-bit word per register
// Notes: offsets are byte addresses
package pced_pkg;
  localparam int PCED_PORTS = 3;
  localparam int PCED_PINS = 8;
  localparam int PCED_AW = 8;
  localparam logic [7:0] PCED_OFS_A_RISE = 8'h00;
  localparam logic [7:0] PCED_OFS_A_FALL = 8'h04;
  localparam logic [7:0] PCED_OFS_A_FLAGS = 8'h08;
  localparam logic [7:0] PCED_OFS_B_RISE = 8'h0c;
  localparam logic [7:0] PCED_OFS_B_FALL = 8'h10;
  localparam logic [7:0] PCED_OFS_B_FLAGS = 8'h14;
  localparam logic [7:0] PCED_OFS_C_RISE = 8'h18;
  localparam logic [7:0] PCED_OFS_C_FALL = 8'h1c;
  localparam logic [7:0] PCED_OFS_C_FLAGS = 8'h20;
  localparam logic [7:0] PCED_OFS_CTRL = 8'h24;
  localparam logic [7:0] PCED_OFS_STATUS = 8'h28;
  localparam int PCED_CTRL_IE_BIT = 0;
  localparam int PCED_STAT_SUM_BIT = 0;
  localparam int PCED_STAT_IRQ_BIT = 1;
  localparam logic [7:0] PCED_BYTE_RST = 8'h00;
  localparam logic [7:0] PCED_DBG_MASK_B = 8'h3f;
  typedef logic [PCED_PINS-1:0] pced_byte_t;
endpackage

// ===== pced_pins_if.sv
// Purpose: carries synchronised pin samples between synchroniser and core
// Assumes: one clock domain
// Notes: none
`timescale 1ns/1ns
interface pced_pins_if #(parameter int W = 24);
  logic [W-1:0] cur;
  logic [W-1:0] prev;
  modport src (output cur, output prev);
  modport dst (input cur, input prev);
endinterface // pced_pins_if

// ===== pced_sync.sv
// Purpose: two-stage synchroniser plus previous-sample register for pin inputs
// Assumes: pins are asynchronous to pclk
// Notes: first stage is read only by the second stage
`timescale 1ns/1ns
module pced_sync #(
  parameter int W = 24
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [W-1:0] pins,
  pced_pins_if.src po
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
  } pced_sync_st_t;
  pced_sync_st_t st_q, st_d;

  always_comb begin
    st_d = st_q;
    st_d.s1 = pins;
    st_d.s2 = st_q.s1;
    st_d.s3 = st_q.s2;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign po.cur = st_q.s2;
  assign po.prev = st_q.s3;
endmodule // pced_sync

// ===== pced_top.sv
// Purpose: pin change edge detector for three 8-bit ports with apb registers
// Assumes: 10 MHz pclk, apb slave with zero wait states
// Notes: wake request and irq are levels
// Operation
// RULE1: an enabled pin change event with the irq enable set raises the wake request.
// RULE2: a set rise enable bit arms low-to-high detection on its pin.
// RULE3: a set fall enable bit arms high-to-low detection, and both may be armed.
// RULE4: a pin flag sets on an armed rising edge or an armed falling edge.
// RULE5: with both enables clear, edges on a pin set no flag.
// RULE6: every detected armed edge sets the summary flag along with the pin flag.
// RULE7: software clears flags by writing zeros; a clear flag reads zero.
// RULE8: all enables and flags reset to zero on every reset.
// RULE9: flags are readable, writable and set by hardware, never cleared by it.
// RULE10: with the debugger enabled, port b bits 7 and 6 are withheld from use.
// RULE11: software should clear flags by and-ing in the inverse of a captured copy.
// RULE12: ports b and c each have eight flags set by armed edges on their pins.
// RULE13: the summary flag is the or of all pin flags.
// RULE14: detection and flag setting go on while the irq enable is clear.
// RULE15: an armed edge during a flag write leaves that flag set.
// RULE16: pins are synchronised and edges found by comparing successive samples.
// RULE17: the irq output is high while summary flag and irq enable are both one.
//
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/1ns
module pced_top
  import pced_pkg::*;
#(
  parameter int NPORT = PCED_PORTS
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [PCED_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] port_a_pin,
  input wire logic [7:0] port_b_pin,
  input wire logic [7:0] port_c_pin,
  input wire logic debug_enable,
  output logic pin_change_irq,
  output logic wake_request
);
  import pced_pkg::*;

  localparam int W = NPORT * PCED_PINS;

  typedef struct packed {
    logic [NPORT-1:0][PCED_PINS-1:0] rise;
    logic [NPORT-1:0][PCED_PINS-1:0] fall;
    logic [NPORT-1:0][PCED_PINS-1:0] flags;
    logic irq_en;
    logic dbg1;
    logic dbg2;
    logic [31:0] rdata;
  } pced_state_t;

  pced_state_t st_q, st_d;
  pced_pins_if #(.W(W)) pins_if ();

  pced_sync #(.W(W)) u_sync ( // RULE16
    .pclk(pclk),
    .presetn(presetn),
    .pins({port_c_pin, port_b_pin, port_a_pin}),
    .po(pins_if)
  );

  logic [W-1:0] rise_edge;
  logic [W-1:0] fall_edge;
  logic [W-1:0] hit;
  logic [W-1:0] avail;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic summary;
  logic [31:0] rd_mux;

  // withhold port b bits 7 and 6 while debugging
  assign avail = st_q.dbg2 ? {8'hff, PCED_DBG_MASK_B, 8'hff} : {W{1'b1}}; // RULE10
  assign rise_edge = pins_if.cur & ~pins_if.prev; // RULE16
  assign fall_edge = ~pins_if.cur & pins_if.prev; // RULE16
  // armed edge hits per pin
  assign hit = avail & ((rise_edge & st_q.rise) | (fall_edge & st_q.fall)); // RULE2 RULE3 RULE5
  assign summary = |st_q.flags; // RULE13
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;

  always_comb begin
    unique case (paddr)
      PCED_OFS_A_RISE, PCED_OFS_A_FALL, PCED_OFS_A_FLAGS,
      PCED_OFS_B_RISE, PCED_OFS_B_FALL, PCED_OFS_B_FLAGS,
      PCED_OFS_C_RISE, PCED_OFS_C_FALL, PCED_OFS_C_FLAGS,
      PCED_OFS_CTRL, PCED_OFS_STATUS: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  always_comb begin
    rd_mux = '0;
    unique case (paddr)
      PCED_OFS_A_RISE: rd_mux[7:0] = st_q.rise[0];
      PCED_OFS_A_FALL: rd_mux[7:0] = st_q.fall[0];
      PCED_OFS_A_FLAGS: rd_mux[7:0] = st_q.flags[0]; // RULE7
      PCED_OFS_B_RISE: rd_mux[7:0] = st_q.rise[1];
      PCED_OFS_B_FALL: rd_mux[7:0] = st_q.fall[1];
      PCED_OFS_B_FLAGS: rd_mux[7:0] = st_q.flags[1]; // RULE12
      PCED_OFS_C_RISE: rd_mux[7:0] = st_q.rise[2];
      PCED_OFS_C_FALL: rd_mux[7:0] = st_q.fall[2];
      PCED_OFS_C_FLAGS: rd_mux[7:0] = st_q.flags[2]; // RULE12
      PCED_OFS_CTRL: rd_mux[PCED_CTRL_IE_BIT] = st_q.irq_en;
      PCED_OFS_STATUS: begin
        rd_mux[PCED_STAT_SUM_BIT] = summary;
        rd_mux[PCED_STAT_IRQ_BIT] = pin_change_irq;
      end
      default: rd_mux = '0;
    endcase
  end

  always_comb begin
    st_d = st_q;
    st_d.dbg1 = debug_enable;
    st_d.dbg2 = st_q.dbg1;
    if (rd_acc) begin
      st_d.rdata = rd_mux;
    end
    if (wr_acc && pstrb[0]) begin
      unique case (paddr)
        PCED_OFS_A_RISE: st_d.rise[0] = pwdata[7:0];
        PCED_OFS_A_FALL: st_d.fall[0] = pwdata[7:0];
        PCED_OFS_A_FLAGS: st_d.flags[0] = pwdata[7:0]; // RULE7 RULE9
        PCED_OFS_B_RISE: st_d.rise[1] = pwdata[7:0];
        PCED_OFS_B_FALL: st_d.fall[1] = pwdata[7:0];
        PCED_OFS_B_FLAGS: st_d.flags[1] = pwdata[7:0]; // RULE7 RULE9
        PCED_OFS_C_RISE: st_d.rise[2] = pwdata[7:0];
        PCED_OFS_C_FALL: st_d.fall[2] = pwdata[7:0];
        PCED_OFS_C_FLAGS: st_d.flags[2] = pwdata[7:0]; // RULE7 RULE9
        PCED_OFS_CTRL: st_d.irq_en = pwdata[PCED_CTRL_IE_BIT];
        default: st_d.irq_en = st_q.irq_en;
      endcase
    end
    // hardware set wins over a software clear in the same cycle
    st_d.flags = st_d.flags | hit; // RULE4 RULE6 RULE14 RULE15
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= '0; // RULE8
    end else begin
      st_q <= st_d;
    end
  end

  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = st_q.rdata;
  assign pin_change_irq = summary && st_q.irq_en; // RULE17
  assign wake_request = summary && st_q.irq_en; // RULE1

  property p_hit_sets_flag;
    @(posedge pclk) disable iff (!presetn)
      (|hit) |=> (summary && ((st_q.flags & $past(hit)) == $past(hit)));
  endproperty
  a_hit_sets_flag: assert property (p_hit_sets_flag) // RULE4
    else $error("armed edge did not set its flag");

  property p_rise_arms;
    @(posedge pclk) disable iff (!presetn)
      (|(rise_edge & st_q.rise & avail)) |=> summary;
  endproperty
  a_rise_arms: assert property (p_rise_arms) // RULE2
    else $error("armed rising edge lost");

  property p_fall_arms;
    @(posedge pclk) disable iff (!presetn)
      (|(fall_edge & st_q.fall & avail)) |=> summary;
  endproperty
  a_fall_arms: assert property (p_fall_arms) // RULE3
    else $error("armed falling edge lost");

  property p_no_hw_clear;
    @(posedge pclk) disable iff (!presetn)
      !wr_acc |=> ((st_q.flags & $past(st_q.flags)) == $past(st_q.flags));
  endproperty
  a_no_hw_clear: assert property (p_no_hw_clear) // RULE9
    else $error("flag cleared without a write");

  property p_unarmed_quiet;
    @(posedge pclk) disable iff (!presetn)
      (!wr_acc && hit == '0) |=> (st_q.flags == $past(st_q.flags));
  endproperty
  a_unarmed_quiet: assert property (p_unarmed_quiet) // RULE5
    else $error("flag set without armed edge");

  property p_irq_level;
    @(posedge pclk) disable iff (!presetn)
      pin_change_irq == (st_q.irq_en && (st_q.flags != '0));
  endproperty
  a_irq_level: assert property (p_irq_level) // RULE17
    else $error("irq does not follow flags and enable");

  property p_detect_without_ie;
    @(posedge pclk) disable iff (!presetn)
      (!st_q.irq_en && |hit && !(wr_acc && paddr == PCED_OFS_CTRL)) |=>
        (summary && !pin_change_irq);
  endproperty
  a_detect_without_ie: assert property (p_detect_without_ie) // RULE14
    else $error("detection stopped while irq enable clear");

  property p_set_beats_clear;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && paddr == PCED_OFS_A_FLAGS && |hit[7:0]) |=>
        ((st_q.flags[0] & $past(hit[7:0])) == $past(hit[7:0]));
  endproperty
  a_set_beats_clear: assert property (p_set_beats_clear) // RULE15
    else $error("edge lost during flag write");

  property p_debug_bits;
    @(posedge pclk) disable iff (!presetn)
      st_q.dbg2 |-> (hit[15:14] == 2'b00);
  endproperty
  a_debug_bits: assert property (p_debug_bits) // RULE10
    else $error("debug-owned pins detected edges");

  property p_wake_follows_irq;
    @(posedge pclk) disable iff (!presetn)
      wake_request == pin_change_irq;
  endproperty
  a_wake_follows_irq: assert property (p_wake_follows_irq) // RULE1
    else $error("wake request differs from irq");

  property p_wake_on_event;
    @(posedge pclk) disable iff (!presetn)
      (st_q.irq_en && |hit && !(wr_acc && paddr == PCED_OFS_CTRL)) |=> wake_request;
  endproperty
  a_wake_on_event: assert property (p_wake_on_event) // RULE1
    else $error("enabled event did not raise wake");

  property p_new_flag_from_hit;
    @(posedge pclk) disable iff (!presetn)
      !wr_acc |=> ((st_q.flags & ~$past(st_q.flags) & ~$past(hit)) == '0);
  endproperty
  a_new_flag_from_hit: assert property (p_new_flag_from_hit) // RULE5
    else $error("flag rose without an armed edge");

  property p_status_summary;
    @(posedge pclk) disable iff (!presetn)
      (rd_acc && paddr == PCED_OFS_STATUS) |=>
        (st_q.rdata[PCED_STAT_SUM_BIT] == ($past(st_q.flags) != '0));
  endproperty
  a_status_summary: assert property (p_status_summary) // RULE13
    else $error("summary bit is not the or of the flags");

  property p_flag_write_stores;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && pstrb[0] && paddr == PCED_OFS_A_FLAGS) |=>
        (st_q.flags[0] == ($past(pwdata[PCED_PINS-1:0]) | $past(hit[PCED_PINS-1:0])));
  endproperty
  a_flag_write_stores: assert property (p_flag_write_stores) // RULE7
    else $error("flag write did not store the written value");

  property p_strobe_off;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && !pstrb[0]) |=> ((st_q.rise == $past(st_q.rise)) &&
        (st_q.fall == $past(st_q.fall)) && (st_q.flags == ($past(st_q.flags) | $past(hit))));
  endproperty
  a_strobe_off: assert property (p_strobe_off) // RULE9
    else $error("write without strobe changed a register");

  property p_unmapped_no_write;
    @(posedge pclk) disable iff (!presetn)
      (wr_acc && !mapped) |=>
        ((st_q.rise == $past(st_q.rise)) && (st_q.irq_en == $past(st_q.irq_en)));
  endproperty
  a_unmapped_no_write: assert property (p_unmapped_no_write)
    else $error("unmapped write changed a register");

  property p_rdata_upper_zero;
    @(posedge pclk) disable iff (!presetn)
      prdata[31:PCED_PINS] == '0;
  endproperty
  a_rdata_upper_zero: assert property (p_rdata_upper_zero)
    else $error("read data upper bits not zero");

  property p_ready_high;
    @(posedge pclk) disable iff (!presetn)
      pready;
  endproperty
  a_ready_high: assert property (p_ready_high)
    else $error("ready dropped");

  property p_rdata_holds;
    @(posedge pclk) disable iff (!presetn)
      !rd_acc |=> $stable(prdata);
  endproperty
  a_rdata_holds: assert property (p_rdata_holds)
    else $error("read data changed without a read");

  property p_prev_sample;
    @(posedge pclk) disable iff (!presetn)
      presetn |=> (pins_if.prev == $past(pins_if.cur));
  endproperty
  a_prev_sample: assert property (p_prev_sample) // RULE16
    else $error("previous sample is not last synchronised sample");

  property p_irq_needs_enable;
    @(posedge pclk) disable iff (!presetn)
      !st_q.irq_en |-> !pin_change_irq;
  endproperty
  a_irq_needs_enable: assert property (p_irq_needs_enable) // RULE14
    else $error("irq raised with enable clear");

  property p_port_c_rise;
    @(posedge pclk) disable iff (!presetn)
      (|(rise_edge[2*PCED_PINS +: PCED_PINS] & st_q.rise[2])) |=>
        (st_q.flags[2] != '0);
  endproperty
  a_port_c_rise: assert property (p_port_c_rise) // RULE12
    else $error("port c armed edge set no flag");

  property p_port_b_rise;
    @(posedge pclk) disable iff (!presetn)
      (|(rise_edge[PCED_PINS +: PCED_PINS] & st_q.rise[1] & avail[PCED_PINS +: PCED_PINS])) |=>
        (st_q.flags[1] != '0);
  endproperty
  a_port_b_rise: assert property (p_port_b_rise) // RULE12
    else $error("port b armed edge set no flag");

  property p_debug_flags_hold;
    @(posedge pclk) disable iff (!presetn)
      (st_q.dbg2 && !wr_acc) |=>
        ((st_q.flags[1] & ~PCED_DBG_MASK_B) == ($past(st_q.flags[1]) & ~PCED_DBG_MASK_B));
  endproperty
  a_debug_flags_hold: assert property (p_debug_flags_hold) // RULE10
    else $error("debug-owned flag changed");

  property p_flag_read;
    @(posedge pclk) disable iff (!presetn)
      (rd_acc && paddr == PCED_OFS_C_FLAGS) |=>
        (st_q.rdata[PCED_PINS-1:0] == $past(st_q.flags[2]));
  endproperty
  a_flag_read: assert property (p_flag_read) // RULE12
    else $error("port c flag read returned wrong value");

  property p_reset_clears;
    @(posedge pclk)
      !presetn |=>
        (st_q.rise == '0 && st_q.fall == '0 && st_q.flags == '0 && !st_q.irq_en);
  endproperty
  a_reset_clears: assert property (p_reset_clears) // RULE8
    else $error("register not zero during reset");
endmodule // pced_top

// ===== pced_pin_model.sv
// Purpose: stands in for the external signals on the three port pins
// Assumes: the bench requests new pin levels between clock edges
// Notes: levels change only just after a rising edge, like a clocked source
`timescale 1ns/1ns
module pced_pin_model (
  input wire logic pclk,
  input wire logic [23:0] want,
  output logic [7:0] port_a_pin,
  output logic [7:0] port_b_pin,
  output logic [7:0] port_c_pin
);
  initial begin
    port_a_pin = 8'h00;
    port_b_pin = 8'h00;
    port_c_pin = 8'h00;
  end
  always @(posedge pclk) begin
    {port_c_pin, port_b_pin, port_a_pin} <= want;
  end
endmodule // pced_pin_model

// ===== pced_tb_top.sv
// Purpose: self-checking bench for the pin change edge detector
// Assumes: zero wait apb slave, flags visible three edges after a pin change
// Notes: one idle cycle between bus transfers
`timescale 1ns/1ns
module pced_tb_top;
  import pced_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic debug_enable = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'h1;
  logic [31:0] prdata, q;
  logic pready, pslverr, pin_change_irq, wake_request, e;
  logic [7:0] pa, pb, pc;
  logic [23:0] want = 24'h0;
  int n_fail = 0, checks = 0, cyc = 0;
  pced_pin_model pced_pin_model_inst (.pclk(pclk), .want(want), .port_a_pin(pa),
    .port_b_pin(pb), .port_c_pin(pc));
  pced_top pced_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .port_a_pin(pa), .port_b_pin(pb),
    .port_c_pin(pc), .debug_enable(debug_enable), .pin_change_irq(pin_change_irq),
    .wake_request(wake_request));
  initial begin
    forever #50 pclk = ~pclk;
  end
  task wrap_up;
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      n_fail++;
      wrap_up;
    end
  end
  task chk(input string s, input logic [31:0] x, input logic [31:0] g);
    checks++;
    if (g !== x) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", s, x, g);
    end
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rd(input logic [7:0] a, input logic [7:0] x, input string s);
    xfer(1'b0, a, 8'h00);
    chk(s, {24'h0, x}, q);
  endtask
  task pins(input logic [23:0] v);
    @(posedge pclk);
    want <= v;
    repeat (5) @(posedge pclk);
  endtask
  initial begin
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 11; i++) rd(8'(i * 4), 8'h00, "reset value");
    xfer(1'b0, 8'h2c, 8'h00);
    chk("unmapped err", 32'h1, {31'h0, e});
    chk("unmapped data", 32'h0, q);
    xfer(1'b1, 8'h2c, 8'hff);
    chk("unmapped wr err", 32'h1, {31'h0, e});
    chk("ready", 32'h1, {31'h0, pready});
    $display("test reset done");
    // bit0 rise only, bit1 fall only, bit2 both, bit3 neither
    xfer(1'b1, PCED_OFS_A_RISE, 8'h05);
    xfer(1'b1, PCED_OFS_A_FALL, 8'h06);
    rd(PCED_OFS_A_FALL, 8'h06, "a fall enable");
    pins(24'h00000f);
    rd(PCED_OFS_A_FLAGS, 8'h05, "a rise flags");
    rd(PCED_OFS_STATUS, 8'h01, "summary no irq");
    chk("irq disabled", 32'h0, {31'h0, pin_change_irq});
    xfer(1'b1, PCED_OFS_CTRL, 8'h01);
    rd(PCED_OFS_STATUS, 8'h03, "summary irq");
    chk("wake", 32'h1, {31'h0, wake_request});
    xfer(1'b1, PCED_OFS_A_FLAGS, 8'h05 & ~8'h05);
    rd(PCED_OFS_STATUS, 8'h00, "cleared summary");
    chk("irq cleared", 32'h0, {31'h0, pin_change_irq});
    pins(24'h000000);
    rd(PCED_OFS_A_FLAGS, 8'h06, "a fall flags");
    rd(PCED_OFS_STATUS, 8'h03, "summary fall");
    xfer(1'b1, PCED_OFS_A_FLAGS, 8'h00);
    // the clear below lands on the same edge as the bit 0 rising edge
    @(posedge pclk);
    want <= 24'h000001;
    @(posedge pclk);
    xfer(1'b1, PCED_OFS_A_FLAGS, 8'h00);
    rd(PCED_OFS_A_FLAGS, 8'h01, "flag set during clear");
    $display("test port a done");
    debug_enable <= 1'b1;
    xfer(1'b1, PCED_OFS_B_RISE, 8'hff);
    pins(24'h00ff00);
    rd(PCED_OFS_B_FLAGS, 8'h3f, "b flags debug");
    debug_enable <= 1'b0;
    xfer(1'b1, PCED_OFS_C_RISE, 8'hff);
    pins(24'hffff00);
    rd(PCED_OFS_C_FLAGS, 8'hff, "c flags");
    pstrb <= 4'h0;
    xfer(1'b1, PCED_OFS_C_RISE, 8'h00);
    pstrb <= 4'h1;
    rd(PCED_OFS_C_RISE, 8'hff, "c rise strobe off");
    rd(PCED_OFS_B_FLAGS, 8'h3f, "b flags sticky");
    $display("test ports b c done");
    presetn <= 1'b0;
    @(posedge pclk);
    presetn <= 1'b1;
    rd(PCED_OFS_C_FLAGS, 8'h00, "c flags after reset");
    rd(PCED_OFS_C_RISE, 8'h00, "c rise after reset");
    chk("irq after reset", 32'h0, {31'h0, pin_change_irq});
    $display("test second reset done");
    wrap_up;
  end
endmodule // pced_tb_top
